//--- core/fes_pkg.sv
// Package for the flash ECC error status block
package fes_pkg;
  // Register byte offsets
  localparam logic [7:0] FES_STATUS_OFF  = 8'h00;
  localparam logic [7:0] FES_IRQ_EN_OFF  = 8'h04;
  localparam logic [7:0] FES_IRQ_ST_OFF  = 8'h08;
  localparam logic [7:0] FES_IRQ_CLR_OFF = 8'h0C;
  // Field positions
  localparam int FES_DED_BIT    = 27;
  localparam int FES_SEC_BIT    = 26;
  localparam int FES_CNT_LSB    = 0;
  localparam int FES_CNT_W      = 8;
  // Interrupt status/enable bit positions
  localparam int FES_EV_SEC     = 0;
  localparam int FES_EV_DED     = 1;
  localparam int FES_EV_W       = 2;
  // Reset values and response codes
  localparam logic [7:0]  FES_CNT_RST  = 8'h00;
  localparam logic [31:0] FES_ZERO32   = 32'h0000_0000;
  localparam logic [1:0]  FES_RESP_OK  = 2'h0;
  localparam logic [1:0]  FES_RESP_ERR = 2'h2;

  // ECC checker event pulses
  typedef struct packed {
    logic sec;
    logic ded;
  } fes_ecc_ev_t;

  // Software write to status word
  typedef struct packed {
    logic       wr;
    logic [3:0] strb;
    logic [31:0] data;
  } fes_sw_wr_t;
endpackage

//--- core/fes_err_core.sv
// Error flags and corrected-error down-counter
`timescale 1ns/10ps
`default_nettype none
module fes_err_core (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               ce,
  // ECC events and software access
  input  wire fes_pkg::fes_ecc_ev_t ev,
  input  wire fes_pkg::fes_sw_wr_t  sw,
  // State
  output logic                    ded_flag,
  output logic                    sec_flag,
  output logic [7:0]              cnt,
  output logic                    sec_set,
  output logic                    ded_set
);
  logic       ded_reg, ded_next;
  logic       sec_reg, sec_next;
  logic [7:0] cnt_reg, cnt_next;

  always_comb begin
    ded_next = ded_reg;
    sec_next = sec_reg;
    cnt_next = cnt_reg;
    // Software write first so hardware set wins over clear
    if (sw.wr && sw.strb[3]) begin
      ded_next = ded_reg & sw.data[fes_pkg::FES_DED_BIT];
      sec_next = sec_reg & sw.data[fes_pkg::FES_SEC_BIT];
    end
    if (sw.wr && sw.strb[0])
      cnt_next = sw.data[7:0];
    // Every corrected error counts, no address filtering
    if (ev.sec) begin
      if (cnt_reg == 8'h00)
        sec_next = 1'b1;
      else
        cnt_next = cnt_reg - 8'h01;
    end
    if (ev.ded)
      ded_next = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ded_reg <= 1'b0;
      sec_reg <= 1'b0;
      cnt_reg <= fes_pkg::FES_CNT_RST;
    end else if (ce) begin
      ded_reg <= ded_next;
      sec_reg <= sec_next;
      cnt_reg <= cnt_next;
    end
  end

  assign ded_flag = ded_reg;
  assign sec_flag = sec_reg;
  assign cnt      = cnt_reg;
  assign sec_set  = ev.sec && (cnt_reg == 8'h00);
  assign ded_set  = ev.ded;
endmodule
`default_nettype wire

//--- core/fes_top.sv
// AXI4-Lite register front end of the flash ECC error status block
`timescale 1ns/10ps
`default_nettype none
module fes_top (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // ECC checker pulses
  input  wire logic        sec_pulse,
  input  wire logic        ded_pulse,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Interrupt
  output logic             irq
);
  fes_pkg::fes_ecc_ev_t ev;
  fes_pkg::fes_sw_wr_t  sw;
  logic       ded_flag, sec_flag, sec_set, ded_set;
  logic [7:0] cnt;

  // Write channel state
  logic [7:0]  awa_reg, awa_next;
  logic        awh_reg, awh_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0]  ws_reg, ws_next;
  logic        wh_reg, wh_next;
  logic        bv_reg, bv_next;
  logic [1:0]  br_reg, br_next;
  // Read channel state
  logic        rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0]  rr_reg, rr_next;
  // Interrupt state
  logic [1:0]  ist_reg, ist_next;
  logic [1:0]  ien_reg, ien_next;

  // One-hot register select, shared by the write and read channels
  typedef enum logic [4:0] {
    SEL_STATUS  = 5'h01,
    SEL_IRQ_EN  = 5'h02,
    SEL_IRQ_ST  = 5'h04,
    SEL_IRQ_CLR = 5'h08,
    SEL_NONE    = 5'h10
  } fes_sel_t;

  logic     do_wr;
  fes_sel_t wsel;
  fes_sel_t rsel;

  // Address decode; unmapped offsets fall to SEL_NONE
  function automatic fes_sel_t reg_sel(input logic [7:0] a);
    fes_sel_t s;
    if (a == fes_pkg::FES_STATUS_OFF) begin
      s = SEL_STATUS;
    end else if (a == fes_pkg::FES_IRQ_EN_OFF) begin
      s = SEL_IRQ_EN;
    end else if (a == fes_pkg::FES_IRQ_ST_OFF) begin
      s = SEL_IRQ_ST;
    end else if (a == fes_pkg::FES_IRQ_CLR_OFF) begin
      s = SEL_IRQ_CLR;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  // One driver for each carrier struct
  assign ev = '{sec: sec_pulse, ded: ded_pulse};

  // Status word with unimplemented bits zero
  function automatic logic [31:0] status_word(input logic d, input logic s,
                                              input logic [7:0] c);
    logic [31:0] w;
    w = fes_pkg::FES_ZERO32;
    w[fes_pkg::FES_DED_BIT] = d;
    w[fes_pkg::FES_SEC_BIT] = s;
    w[7:0] = c;
    return w;
  endfunction

  // Readies drop with ce, so no request is taken while state is frozen.
  // Limitation: B and R handshakes only retire while ce is high.
  assign s_awready = ce && !awh_reg && !bv_reg;
  assign s_wready  = ce && !wh_reg && !bv_reg;
  assign s_arready = ce && !rv_reg;
  assign do_wr     = awh_reg && wh_reg && !bv_reg;
  assign wsel      = reg_sel(awa_reg);
  assign rsel      = reg_sel(s_araddr);

  assign sw = '{wr:   do_wr && (wsel == SEL_STATUS),
                strb: ws_reg,
                data: wd_reg};

  fes_err_core u_core (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .ev       (ev),
    .sw       (sw),
    .ded_flag (ded_flag),
    .sec_flag (sec_flag),
    .cnt      (cnt),
    .sec_set  (sec_set),
    .ded_set  (ded_set)
  );

  // Write address, write data and write response channels
  always_comb begin
    awa_next = awa_reg;
    awh_next = awh_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    wh_next  = wh_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    if (s_awvalid && s_awready) begin
      awa_next = s_awaddr;
      awh_next = 1'b1;
    end
    if (s_wvalid && s_wready) begin
      wd_next = s_wdata;
      ws_next = s_wstrb;
      wh_next = 1'b1;
    end
    if (do_wr) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      // Unmapped offsets answer with an error and change nothing
      if (wsel == SEL_NONE) begin
        br_next = fes_pkg::FES_RESP_ERR;
      end else begin
        br_next = fes_pkg::FES_RESP_OK;
      end
    end else if (bv_reg && s_bready) begin
      bv_next = 1'b0;
    end
  end

  // Interrupt enable and sticky interrupt status
  always_comb begin
    ien_next = ien_reg;
    ist_next = ist_reg;
    if (do_wr && ws_reg[0]) begin
      if (wsel == SEL_IRQ_EN) begin
        ien_next = wd_reg[1:0];
      end else if (wsel == SEL_IRQ_CLR) begin
        ist_next = ist_reg & ~wd_reg[1:0];
      end
    end
    // Hardware set wins over a same-cycle clear
    if (sec_set)
      ist_next[fes_pkg::FES_EV_SEC] = 1'b1;
    if (ded_set)
      ist_next[fes_pkg::FES_EV_DED] = 1'b1;
  end

  always_comb begin
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_arvalid && s_arready) begin
      rv_next = 1'b1;
      rr_next = fes_pkg::FES_RESP_OK;
      rd_next = fes_pkg::FES_ZERO32;
      // Clear register reads as zero through the default above
      if (rsel == SEL_STATUS) begin
        rd_next = status_word(ded_flag, sec_flag, cnt);
      end else if (rsel == SEL_IRQ_EN) begin
        rd_next[1:0] = ien_reg;
      end else if (rsel == SEL_IRQ_ST) begin
        rd_next[1:0] = ist_reg;
      end else if (rsel == SEL_NONE) begin
        rr_next = fes_pkg::FES_RESP_ERR;
      end
    end else if (rv_reg && s_rready) begin
      rv_next = 1'b0;
    end
  end

  // Write channel registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      awa_reg <= 8'h00;
      awh_reg <= 1'b0;
      wd_reg  <= fes_pkg::FES_ZERO32;
      ws_reg  <= 4'h0;
      wh_reg  <= 1'b0;
      bv_reg  <= 1'b0;
      br_reg  <= fes_pkg::FES_RESP_OK;
    end else if (ce) begin
      awa_reg <= awa_next;
      awh_reg <= awh_next;
      wd_reg  <= wd_next;
      ws_reg  <= ws_next;
      wh_reg  <= wh_next;
      bv_reg  <= bv_next;
      br_reg  <= br_next;
    end
  end

  // Read channel registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rv_reg <= 1'b0;
      rd_reg <= fes_pkg::FES_ZERO32;
      rr_reg <= fes_pkg::FES_RESP_OK;
    end else if (ce) begin
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end

  // Interrupt registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ist_reg <= 2'h0;
      ien_reg <= 2'h0;
    end else if (ce) begin
      ist_reg <= ist_next;
      ien_reg <= ien_next;
    end
  end

  assign s_bvalid = bv_reg;
  assign s_bresp  = br_reg;
  assign s_rvalid = rv_reg;
  assign s_rdata  = rd_reg;
  assign s_rresp  = rr_reg;
  // Level interrupt from enabled sticky bits
  assign irq = |(ist_reg & ien_reg);
endmodule
`default_nettype wire

//--- tb/fes_properties.sv
// Port-level checker for the flash ECC error status block
`timescale 1ns/10ps
`default_nettype none
module fes_props (
  // Clock, reset, events
  input wire logic        mclk, nrst, ce, sec_pulse, ded_pulse,
  // Register bus
  input wire logic [7:0]  s_awaddr, s_araddr,
  input wire logic        s_awvalid, s_awready, s_wvalid, s_wready,
  input wire logic [31:0] s_wdata, s_rdata,
  input wire logic [3:0]  s_wstrb,
  input wire logic [1:0]  s_bresp, s_rresp,
  input wire logic        s_bvalid, s_bready, s_arvalid, s_arready,
  input wire logic        s_rvalid, s_rready, irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  rd_zero_a: assert property (s_rvalid |-> s_rdata[31:28] == 4'h0 &&
    s_rdata[25:8] == 18'h0) else $error("unused status bits set");
  irq_rise_a: assert property ($rose(irq) |->
    $past(sec_pulse) || $past(ded_pulse) || $rose(s_bvalid))
    else $error("irq rose");
  irq_fall_a: assert property ($fell(irq) |-> $rose(s_bvalid))
    else $error("irq fell without write");
  wr_lat_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready
    |-> ##2 s_bvalid) else $error("write answer late");
  rd_lat_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid &&
    $stable(s_rdata)) else $error("read data moved");
  w_refuse_a: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while answering");
  ar_refuse_a: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while answering");
  err_zero_a: assert property (s_rvalid && s_rresp == 2'h2 |->
    s_rdata == 32'h0) else $error("error read data");
  cov_irq: cover property ($rose(irq));
  cov_rd: cover property (s_rvalid && s_rready);
  cov_wr: cover property (s_bvalid && s_bready);
endmodule
bind fes_top fes_props u_props (.mclk(mclk), .nrst(nrst), .ce(ce),
  .sec_pulse(sec_pulse), .ded_pulse(ded_pulse), .s_awaddr(s_awaddr),
  .s_araddr(s_araddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
  .s_rdata(s_rdata), .s_wstrb(s_wstrb), .s_bresp(s_bresp),
  .s_rresp(s_rresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .irq(irq));
`default_nettype wire

//--- tb/fes_ecc_model.sv
// Flash ECC checker model issuing error pulses
`timescale 1ns/10ps
`default_nettype none
module fes_ecc_model (
  input  wire logic mclk,
  output var logic  sec_pulse,
  output var logic  ded_pulse
);
  initial begin
    sec_pulse = 1'b0;
    ded_pulse = 1'b0;
  end
  // Back-to-back pulses model repeats at one address
  task automatic fire(input int n, input logic d);
    repeat (n) begin
      @(posedge mclk);
      if (d) ded_pulse <= 1'b1;
      else sec_pulse <= 1'b1;
    end
    @(posedge mclk);
    sec_pulse <= 1'b0;
    ded_pulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/flash_ecc_error_status_test.sv
// Self-checking bench for the flash ECC error status block
`timescale 1ns/10ps
`default_nettype none
module flash_ecc_error_status_test;
  logic        mclk = 1'b0, nrst = 1'b0, ce = 1'b1, sec_pulse, ded_pulse;
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd;
  logic [3:0]  s_wstrb = 4'h0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic        s_arvalid = 1'b0, s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [1:0]  s_bresp, s_rresp;
  int          bad_count = 0, compares = 0;
  always #4 mclk = ~mclk;
  fes_top dut (.mclk(mclk), .nrst(nrst), .ce(ce), .sec_pulse(sec_pulse),
    .ded_pulse(ded_pulse), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .irq(irq));
  fes_ecc_model ecc (.mclk(mclk), .sec_pulse(sec_pulse),
    .ded_pulse(ded_pulse));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic chi(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // Handshakes judged at the falling edge, acted on at the next rise
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] st, input logic [1:0] er);
    logic ta, tw, tb;
    int   n;
    n = 0;
    @(posedge mclk);
    s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wstrb <= st;
    s_wvalid <= 1'b1; s_bready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_awvalid && s_awready; tw = s_wvalid && s_wready; tb = s_bvalid;
      if (tb) chk({30'h0, s_bresp}, {30'h0, er});
      @(posedge mclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      if (tb) s_bready <= 1'b0;
      n++;
    end while (!tb && n < 50);
    if (!tb) chk(32'h0, 32'h1);
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    logic tr, ta;
    int   n;
    n = 0;
    @(posedge mclk);
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_arvalid && s_arready;
      tr = s_rvalid; rd = s_rdata;
      if (tr) chk({30'h0, s_rresp}, {30'h0, er});
      @(posedge mclk);
      if (ta) s_arvalid <= 1'b0;
      if (tr) s_rready <= 1'b0;
      n++;
    end while (!tr && n < 50);
    if (!tr) chk(32'h0, 32'h1);
  endtask
  task automatic t_count;
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, fes_pkg::FES_ZERO32);
    axw(fes_pkg::FES_IRQ_EN_OFF, 32'h1, 4'hF, fes_pkg::FES_RESP_OK);
    axw(fes_pkg::FES_STATUS_OFF, 32'h4, 4'h1, fes_pkg::FES_RESP_OK);
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, 32'h0000_0004);
    ecc.fire(3, 1'b0);
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, 32'h0000_0001);
    chi(1'b0);
    ecc.fire(2, 1'b0);
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, 32'h0400_0000);
    chi(1'b1);
    axw(fes_pkg::FES_IRQ_CLR_OFF, 32'h1, 4'hF, fes_pkg::FES_RESP_OK);
    chi(1'b0);
    $display("count test done");
  endtask
  task automatic t_ded;
    ecc.fire(1, 1'b1);
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, 32'h0C00_0000);
    chi(1'b0);
    axw(fes_pkg::FES_STATUS_OFF, 32'hFFFF_FFFF, 4'h8, fes_pkg::FES_RESP_OK);
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, 32'h0C00_0000);
    axw(fes_pkg::FES_STATUS_OFF, 32'h0, 4'h8, fes_pkg::FES_RESP_OK);
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, fes_pkg::FES_ZERO32);
    axw(fes_pkg::FES_IRQ_EN_OFF, 32'h2, 4'hF, fes_pkg::FES_RESP_OK);
    chi(1'b1);
    axw(fes_pkg::FES_IRQ_CLR_OFF, 32'h2, 4'hF, fes_pkg::FES_RESP_OK);
    chi(1'b0);
    axw(8'h10, 32'h1, 4'hF, fes_pkg::FES_RESP_ERR);
    axr(8'h10, fes_pkg::FES_RESP_ERR);
    chk(rd, fes_pkg::FES_ZERO32);
    $display("double error test done");
  endtask
  // Event while ce is low must be lost, state frozen
  task automatic t_ce;
    axw(fes_pkg::FES_STATUS_OFF, 32'h2, 4'h1, fes_pkg::FES_RESP_OK);
    ce <= 1'b0;
    ecc.fire(1, 1'b0);
    ce <= 1'b1;
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, 32'h0000_0002);
    ecc.fire(1, 1'b0);
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, 32'h0000_0001);
    $display("clock enable test done");
  endtask
  // Mid-run reset with DED flag, counter and interrupt live
  task automatic t_reset;
    axw(fes_pkg::FES_IRQ_EN_OFF, 32'h2, 4'hF, fes_pkg::FES_RESP_OK);
    ecc.fire(1, 1'b1);
    chi(1'b1);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    axr(fes_pkg::FES_STATUS_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, fes_pkg::FES_ZERO32);
    axr(fes_pkg::FES_IRQ_EN_OFF, fes_pkg::FES_RESP_OK);
    chk(rd, fes_pkg::FES_ZERO32);
    chi(1'b0);
    $display("reset test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_count;
    t_ded;
    t_ce;
    t_reset;
    report_and_stop;
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
